// ### hw/dcc_cursor_ctrl.sv
// Purpose: Cursor registers and movement for a display controller
// Assumes: Host byte port on core clock; window and font size from other blocks
// Notes:   Software writes to a position win over a same-cycle advance
//
// Overview of operation
// - Sprite shown only while aux bit 7 set
// - Sprite placed at its four position bytes
// - Read cursor never shown, kept separately
// - Main bit 0 set stops read advance
// - Two-bit read direction selects scan order
// - Read cursor: 10-bit X, 9-bit Y
// - Reads advance in graphic and text mode
// - Main bit 7 selects text mode
// - Write cursor marks graphic writes, visible
// - Bits 3-2 set graphic write order
// - Bit 1 set holds write cursor
// - Write cursor: 10-bit X, 9-bit Y
// - Font cursor only in text mode
// - Font cursor advances by font size
// - Wrap at window edge plus line gap
// - Bit 6 shows write and font cursors
// - Bit 5 selects blinking cursor display
// - Blink phase lasts programmed frame count
// - Shown cursor follows main bit 7 mode
//
// The strobed register port was left to the implementer.
`timescale 1ns/100ps
module dcc_cursor_ctrl
  import dcc_pkg::*;
#(
  parameter int XW = XW_DEF,
  parameter int YW = YW_DEF
) (
  input  wire logic          core_clk,
  input  wire logic          sys_rst,
  input  wire logic [7:0]    regAddr,
  input  wire logic [7:0]    regWrData,
  input  wire logic          regWr,
  input  wire logic          regRd,
  output logic      [7:0]    regRdData,
  input  wire logic          memRdDone,
  input  wire logic          memWrDone,
  input  wire logic          charWrDone,
  input  wire logic          framePulse,
  input  wire logic [5:0]    fontWidth,
  input  wire logic [5:0]    fontHeight,
  input  wire logic          fontRotated,
  input  wire logic [XW-1:0] winLeft,
  input  wire logic [XW-1:0] winRight,
  input  wire logic [YW-1:0] winTop,
  input  wire logic [YW-1:0] winBottom,
  output logic               textMode,
  output logic               spriteShow,
  output logic [XW-1:0]      spriteX,
  output logic [YW-1:0]      spriteY,
  output logic [7:0]         spriteColourA,
  output logic [7:0]         spriteColourB,
  output logic [XW-1:0]      readX,
  output logic [YW-1:0]      readY,
  output logic [XW-1:0]      writeX,
  output logic [YW-1:0]      writeY,
  output logic [XW-1:0]      textX,
  output logic [YW-1:0]      textY,
  output logic               writeCursorShow,
  output logic               textCursorShow
);
  if (XW < 9 || XW > 16 || YW < 9 || YW > 16) begin : g_width_check
    $error("Cursor widths must lie between 9 and 16 bits");
  end

  typedef struct packed {
    logic [7:0]    ctlMain;
    logic [7:0]    ctlAux;
    logic [7:0]    blinkFrames;
    logic [7:0]    readOrder;
    logic [7:0]    lineGap;
    logic [7:0]    colA;
    logic [7:0]    colB;
    logic [XW-1:0] rdX;
    logic [YW-1:0] rdY;
    logic [XW-1:0] wrX;
    logic [YW-1:0] wrY;
    logic [XW-1:0] txX;
    logic [YW-1:0] txY;
    logic [XW-1:0] spX;
    logic [YW-1:0] spY;
    logic [7:0]    rdData;
  } dcc_state_s;

  dcc_state_s st_q;
  dcc_state_s st_d;
  dcc_blink_if blinkBus ();

  // Byte-lane helpers for split coordinates
  function automatic logic [XW-1:0] setXLo(input logic [XW-1:0] v, input logic [7:0] b);
    setXLo = {v[XW-1:8], b};
  endfunction : setXLo

  function automatic logic [XW-1:0] setXHi(input logic [XW-1:0] v, input logic [7:0] b);
    setXHi = {b[XW-9:0], v[7:0]};
  endfunction : setXHi

  function automatic logic [YW-1:0] setYLo(input logic [YW-1:0] v, input logic [7:0] b);
    setYLo = {v[YW-1:8], b};
  endfunction : setYLo

  function automatic logic [YW-1:0] setYHi(input logic [YW-1:0] v, input logic [7:0] b);
    setYHi = {b[YW-9:0], v[7:0]};
  endfunction : setYHi

  function automatic logic [7:0] hiX(input logic [XW-1:0] v);
    hiX = 8'(v >> 8);
  endfunction : hiX

  function automatic logic [7:0] hiY(input logic [YW-1:0] v);
    hiY = 8'(v >> 8);
  endfunction : hiY

  // One pixel step in scan order, wrapping inside the window
  function automatic logic [XW+YW-1:0] stepPos(
    input logic [1:0]    dir,
    input logic [XW-1:0] x,
    input logic [YW-1:0] y,
    input logic [XW-1:0] l,
    input logic [XW-1:0] r,
    input logic [YW-1:0] t,
    input logic [YW-1:0] b
  );
    logic [XW-1:0] nx;
    logic [YW-1:0] ny;
    nx = x;
    ny = y;
    case (dcc_dir_e'(dir))
      DIR_RIGHT_DOWN: begin
        if (x >= r) begin
          nx = l;
          ny = (y >= b) ? t : YW'(y + 1'b1);
        end else begin
          nx = XW'(x + 1'b1);
        end
      end
      DIR_LEFT_DOWN: begin
        if (x <= l) begin
          nx = r;
          ny = (y >= b) ? t : YW'(y + 1'b1);
        end else begin
          nx = XW'(x - 1'b1);
        end
      end
      DIR_DOWN_RIGHT: begin
        if (y >= b) begin
          ny = t;
          nx = (x >= r) ? l : XW'(x + 1'b1);
        end else begin
          ny = YW'(y + 1'b1);
        end
      end
      DIR_UP_RIGHT: begin
        if (y <= t) begin
          ny = b;
          nx = (x >= r) ? l : XW'(x + 1'b1);
        end else begin
          ny = YW'(y - 1'b1);
        end
      end
      default: begin
        nx = x;
        ny = y;
      end
    endcase
    stepPos = {nx, ny};
  endfunction : stepPos

  // Character step: along the line, then next line plus gap
  function automatic logic [XW+YW-1:0] fontStep(
    input logic [XW-1:0] x,
    input logic [YW-1:0] y,
    input logic [5:0]    w,
    input logic [5:0]    h,
    input logic [4:0]    gap,
    input logic          rot
  );
    logic [XW+1:0] ax;
    logic [YW+1:0] ay;
    logic [XW-1:0] nx;
    logic [YW-1:0] ny;
    nx = x;
    ny = y;
    if (!rot) begin
      ax = (XW+2)'(x) + (XW+2)'(w) + (XW+2)'(w);
      ay = (YW+2)'(y) + (YW+2)'(h) + (YW+2)'(gap) + (YW+2)'(h);
      if (ax > (XW+2)'(winRight) + 1'b1) begin
        nx = winLeft;
        ny = (ay > (YW+2)'(winBottom) + 1'b1) ? winTop
                                               : YW'(y + YW'(h) + YW'(gap));
      end else begin
        nx = XW'(x + XW'(w));
      end
    end else begin
      // Rotated text runs down a column, columns step rightward
      ay = (YW+2)'(y) + (YW+2)'(w) + (YW+2)'(w);
      ax = (XW+2)'(x) + (XW+2)'(h) + (XW+2)'(gap) + (XW+2)'(h);
      if (ay > (YW+2)'(winBottom) + 1'b1) begin
        ny = winTop;
        nx = (ax > (XW+2)'(winRight) + 1'b1) ? winLeft
                                              : XW'(x + XW'(h) + XW'(gap));
      end else begin
        ny = YW'(y + YW'(w));
      end
    end
    fontStep = {nx, ny};
  endfunction : fontStep

  logic             wrSel;
  logic [XW+YW-1:0] rdNext;
  logic [XW+YW-1:0] wrNext;
  logic [XW+YW-1:0] txNext;

  always_comb begin
    st_d   = st_q;
    wrSel  = regWr;
    rdNext = stepPos(st_q.readOrder[RD_DIR_W-1:0], st_q.rdX, st_q.rdY,
                     winLeft, winRight, winTop, winBottom);
    wrNext = stepPos(st_q.ctlMain[BIT_WR_DIR_HI:BIT_WR_DIR_LO], st_q.wrX, st_q.wrY,
                     winLeft, winRight, winTop, winBottom);
    txNext = fontStep(st_q.txX, st_q.txY, fontWidth, fontHeight,
                      st_q.lineGap[LINE_GAP_W-1:0], fontRotated);

    if (memRdDone && !st_q.ctlMain[BIT_RD_HOLD]) begin
      {st_d.rdX, st_d.rdY} = rdNext;
    end
    if (memWrDone && !st_q.ctlMain[BIT_TEXT_MODE] && !st_q.ctlMain[BIT_WR_HOLD]) begin
      {st_d.wrX, st_d.wrY} = wrNext;
    end
    if (charWrDone && st_q.ctlMain[BIT_TEXT_MODE] && !st_q.ctlMain[BIT_WR_HOLD]) begin
      {st_d.txX, st_d.txY} = txNext;
    end

    if (wrSel) begin
      case (regAddr)
        OFS_LINE_GAP:  st_d.lineGap     = {3'h0, regWrData[LINE_GAP_W-1:0]};
        OFS_TXT_X_LO:  st_d.txX         = setXLo(st_q.txX, regWrData);
        OFS_TXT_X_HI:  st_d.txX         = setXHi(st_q.txX, regWrData);
        OFS_TXT_Y_LO:  st_d.txY         = setYLo(st_q.txY, regWrData);
        OFS_TXT_Y_HI:  st_d.txY         = setYHi(st_q.txY, regWrData);
        OFS_CTL_MAIN:  st_d.ctlMain     = {regWrData[7:5], 1'b0, regWrData[3:0]};
        OFS_CTL_AUX:   st_d.ctlAux      = regWrData;
        OFS_BLINK:     st_d.blinkFrames = regWrData;
        OFS_RD_ORDER:  st_d.readOrder   = {6'h00, regWrData[RD_DIR_W-1:0]};
        OFS_WR_X_LO:   st_d.wrX         = setXLo(st_q.wrX, regWrData);
        OFS_WR_X_HI:   st_d.wrX         = setXHi(st_q.wrX, regWrData);
        OFS_WR_Y_LO:   st_d.wrY         = setYLo(st_q.wrY, regWrData);
        OFS_WR_Y_HI:   st_d.wrY         = setYHi(st_q.wrY, regWrData);
        OFS_RD_X_LO:   st_d.rdX         = setXLo(st_q.rdX, regWrData);
        OFS_RD_X_HI:   st_d.rdX         = setXHi(st_q.rdX, regWrData);
        OFS_RD_Y_LO:   st_d.rdY         = setYLo(st_q.rdY, regWrData);
        OFS_RD_Y_HI:   st_d.rdY         = setYHi(st_q.rdY, regWrData);
        OFS_SPR_X_LO:  st_d.spX         = setXLo(st_q.spX, regWrData);
        OFS_SPR_X_HI:  st_d.spX         = setXHi(st_q.spX, regWrData);
        OFS_SPR_Y_LO:  st_d.spY         = setYLo(st_q.spY, regWrData);
        OFS_SPR_Y_HI:  st_d.spY         = setYHi(st_q.spY, regWrData);
        OFS_SPR_COL_A: st_d.colA        = regWrData;
        OFS_SPR_COL_B: st_d.colB        = regWrData;
        default:       st_d.colB        = st_d.colB;
      endcase
    end

    // Read data valid only in the cycle after the strobe
    st_d.rdData = 8'h00;
    if (regRd) begin
      case (regAddr)
        OFS_LINE_GAP:  st_d.rdData = st_q.lineGap;
        OFS_TXT_X_LO:  st_d.rdData = st_q.txX[7:0];
        OFS_TXT_X_HI:  st_d.rdData = hiX(st_q.txX);
        OFS_TXT_Y_LO:  st_d.rdData = st_q.txY[7:0];
        OFS_TXT_Y_HI:  st_d.rdData = hiY(st_q.txY);
        OFS_CTL_MAIN:  st_d.rdData = st_q.ctlMain;
        OFS_CTL_AUX:   st_d.rdData = st_q.ctlAux;
        OFS_BLINK:     st_d.rdData = st_q.blinkFrames;
        OFS_RD_ORDER:  st_d.rdData = st_q.readOrder;
        OFS_WR_X_LO:   st_d.rdData = st_q.wrX[7:0];
        OFS_WR_X_HI:   st_d.rdData = hiX(st_q.wrX);
        OFS_WR_Y_LO:   st_d.rdData = st_q.wrY[7:0];
        OFS_WR_Y_HI:   st_d.rdData = hiY(st_q.wrY);
        OFS_RD_X_LO:   st_d.rdData = st_q.rdX[7:0];
        OFS_RD_X_HI:   st_d.rdData = hiX(st_q.rdX);
        OFS_RD_Y_LO:   st_d.rdData = st_q.rdY[7:0];
        OFS_RD_Y_HI:   st_d.rdData = hiY(st_q.rdY);
        OFS_SPR_X_LO:  st_d.rdData = st_q.spX[7:0];
        OFS_SPR_X_HI:  st_d.rdData = hiX(st_q.spX);
        OFS_SPR_Y_LO:  st_d.rdData = st_q.spY[7:0];
        OFS_SPR_Y_HI:  st_d.rdData = hiY(st_q.spY);
        OFS_SPR_COL_A: st_d.rdData = st_q.colA;
        OFS_SPR_COL_B: st_d.rdData = st_q.colB;
        default:       st_d.rdData = 8'h00;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      st_q <= '{ctlMain: RST_CTL_MAIN, ctlAux: RST_CTL_AUX, blinkFrames: RST_BLINK,
                readOrder: RST_BYTE, lineGap: RST_BYTE, colA: RST_BYTE, colB: RST_BYTE,
                rdX: '0, rdY: '0, wrX: '0, wrY: '0, txX: '0, txY: '0,
                spX: '0, spY: '0, rdData: RST_BYTE};
    end else begin
      st_q <= st_d;
    end
  end

  assign blinkBus.blinkEn     = st_q.ctlMain[BIT_CUR_BLINK];
  assign blinkBus.blinkFrames = st_q.blinkFrames;
  assign blinkBus.framePulse  = framePulse;

  dcc_blink_gen u_blink (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .blk      (blinkBus.gen)
  );

  logic cursorLit;
  assign cursorLit = st_q.ctlMain[BIT_CUR_SHOW] &
                     (~st_q.ctlMain[BIT_CUR_BLINK] | blinkBus.phaseOn);

  assign textMode        = st_q.ctlMain[BIT_TEXT_MODE];
  assign writeCursorShow = cursorLit & ~st_q.ctlMain[BIT_TEXT_MODE];
  assign textCursorShow  = cursorLit & st_q.ctlMain[BIT_TEXT_MODE];
  assign spriteShow      = st_q.ctlAux[BIT_SPR_SHOW];
  assign spriteX         = st_q.spX;
  assign spriteY         = st_q.spY;
  assign spriteColourA   = st_q.colA;
  assign spriteColourB   = st_q.colB;
  assign readX           = st_q.rdX;
  assign readY           = st_q.rdY;
  assign writeX          = st_q.wrX;
  assign writeY          = st_q.wrY;
  assign textX           = st_q.txX;
  assign textY           = st_q.txY;
  assign regRdData       = st_q.rdData;
endmodule : dcc_cursor_ctrl

// ### hw/dcc_pkg.sv
// Purpose: Constants shared by the display cursor control block
// Assumes: Byte-wide register port, one core clock
// Notes:   Offsets are byte register addresses on the host port
package dcc_pkg;
  localparam int XW_DEF = 10;
  localparam int YW_DEF = 9;

  localparam logic [7:0] OFS_LINE_GAP   = 8'h29;
  localparam logic [7:0] OFS_TXT_X_LO   = 8'h2A;
  localparam logic [7:0] OFS_TXT_X_HI   = 8'h2B;
  localparam logic [7:0] OFS_TXT_Y_LO   = 8'h2C;
  localparam logic [7:0] OFS_TXT_Y_HI   = 8'h2D;
  localparam logic [7:0] OFS_CTL_MAIN   = 8'h40;
  localparam logic [7:0] OFS_CTL_AUX    = 8'h41;
  localparam logic [7:0] OFS_BLINK      = 8'h44;
  localparam logic [7:0] OFS_RD_ORDER   = 8'h45;
  localparam logic [7:0] OFS_WR_X_LO    = 8'h46;
  localparam logic [7:0] OFS_WR_X_HI    = 8'h47;
  localparam logic [7:0] OFS_WR_Y_LO    = 8'h48;
  localparam logic [7:0] OFS_WR_Y_HI    = 8'h49;
  localparam logic [7:0] OFS_RD_X_LO    = 8'h4A;
  localparam logic [7:0] OFS_RD_X_HI    = 8'h4B;
  localparam logic [7:0] OFS_RD_Y_LO    = 8'h4C;
  localparam logic [7:0] OFS_RD_Y_HI    = 8'h4D;
  localparam logic [7:0] OFS_SPR_X_LO   = 8'h80;
  localparam logic [7:0] OFS_SPR_X_HI   = 8'h81;
  localparam logic [7:0] OFS_SPR_Y_LO   = 8'h82;
  localparam logic [7:0] OFS_SPR_Y_HI   = 8'h83;
  localparam logic [7:0] OFS_SPR_COL_A  = 8'h84;
  localparam logic [7:0] OFS_SPR_COL_B  = 8'h85;

  // Main write control fields
  localparam int BIT_TEXT_MODE   = 7;
  localparam int BIT_CUR_SHOW    = 6;
  localparam int BIT_CUR_BLINK   = 5;
  localparam int BIT_WR_DIR_HI   = 3;
  localparam int BIT_WR_DIR_LO   = 2;
  localparam int BIT_WR_HOLD     = 1;
  localparam int BIT_RD_HOLD     = 0;
  // Aux write control field
  localparam int BIT_SPR_SHOW    = 7;
  // Line gap and read direction field widths
  localparam int LINE_GAP_W      = 5;
  localparam int RD_DIR_W        = 2;

  localparam logic [7:0] RST_CTL_MAIN = 8'h00;
  localparam logic [7:0] RST_CTL_AUX  = 8'h00;
  localparam logic [7:0] RST_BLINK    = 8'h00;
  localparam logic [7:0] RST_BYTE     = 8'h00;

  typedef enum logic [1:0] {
    DIR_RIGHT_DOWN,
    DIR_LEFT_DOWN,
    DIR_DOWN_RIGHT,
    DIR_UP_RIGHT
  } dcc_dir_e;
endpackage : dcc_pkg

// ### hw/dcc_blink_if.sv
// Purpose: Carries blink control and phase between the cursor blocks
// Assumes: Same clock on both sides
// Notes:   Frame pulse is one cycle per display frame
`timescale 1ns/100ps
interface dcc_blink_if;
  logic       blinkEn;
  logic [7:0] blinkFrames;
  logic       framePulse;
  logic       phaseOn;
  modport ctrl (output blinkEn, output blinkFrames, output framePulse, input phaseOn);
  modport gen  (input blinkEn, input blinkFrames, input framePulse, output phaseOn);
endinterface : dcc_blink_if

// ### hw/dcc_blink_gen.sv
// Purpose: Blink phase generator counted in display frames
// Assumes: Frame pulse from display timing on core clock
// Notes:   A zero frame count behaves as one frame per phase
`timescale 1ns/100ps
module dcc_blink_gen
  import dcc_pkg::*;
(
  input  wire logic core_clk,
  input  wire logic sys_rst,
  dcc_blink_if.gen  blk
);
  typedef struct packed {
    logic [7:0] frameCnt;
    logic       on;
    logic       enPrev;
  } dcc_blink_s;

  dcc_blink_s st_q;
  dcc_blink_s st_d;
  logic [7:0] limit;

  always_comb begin
    st_d   = st_q;
    limit  = (blk.blinkFrames == 8'h00) ? 8'h01 : blk.blinkFrames;
    st_d.enPrev = blk.blinkEn;
    if (!blk.blinkEn) begin
      st_d.on       = 1'b1;
      st_d.frameCnt = 8'h00;
    end else if (!st_q.enPrev) begin
      st_d.on       = 1'b1;
      st_d.frameCnt = 8'h00;
    end else if (blk.framePulse) begin
      if (st_q.frameCnt + 8'h01 >= limit) begin
        st_d.frameCnt = 8'h00;
        st_d.on       = ~st_q.on;
      end else begin
        st_d.frameCnt = st_q.frameCnt + 8'h01;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      st_q <= '{frameCnt: 8'h00, on: 1'b1, enPrev: 1'b0};
    end else begin
      st_q <= st_d;
    end
  end

  assign blk.phaseOn = st_q.on;
endmodule : dcc_blink_gen

// ### verif/dcc_host_model.sv
// Purpose: Host microcontroller side of the cursor block register port
// Assumes: One-cycle strobes, read data in the cycle after the read strobe
// Notes:   Data lines show the inverse value once a write is over
`timescale 1ns/100ps
module dcc_host_model
  import dcc_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic [7:0] regRdData,
  output logic      [7:0] regAddr,
  output logic      [7:0] regWrData,
  output logic            regWr,
  output logic            regRd
);
  initial begin
    regAddr   = 8'h00;
    regWrData = 8'h00;
    regWr     = 1'b0;
    regRd     = 1'b0;
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    regAddr   <= a;
    regWrData <= d;
    regWr     <= 1'b1;
    @(posedge core_clk);
    regWr     <= 1'b0;
    regWrData <= ~d;
    #1;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge core_clk);
    regRd   <= 1'b0;
    #1;
    d = regRdData;
  endtask : rd

  task automatic show_sprite(input logic [7:0] ca, input logic [7:0] cb,
                             input logic [9:0] x, input logic [8:0] y);
    wr(OFS_SPR_COL_A, ca);
    wr(OFS_SPR_COL_B, cb);
    wr(OFS_CTL_AUX, 8'h80);
    wr(OFS_SPR_X_LO, x[7:0]);
    wr(OFS_SPR_X_HI, {6'h00, x[9:8]});
    wr(OFS_SPR_Y_LO, y[7:0]);
    wr(OFS_SPR_Y_HI, {7'h00, y[8]});
  endtask : show_sprite
endmodule : dcc_host_model

// ### verif/dcc_cursor_properties.sv
// Purpose: Port-level properties of the cursor control block
// Assumes: One clock, synchronous reset
// Notes:   Shadows main control and read order from host writes
`timescale 1ns/100ps
module dcc_cursor_properties
  import dcc_pkg::*;
#(
  parameter int XW = XW_DEF,
  parameter int YW = YW_DEF
) (
  input wire logic          core_clk,
  input wire logic          sys_rst,
  input wire logic [7:0]    regAddr,
  input wire logic [7:0]    regWrData,
  input wire logic          regWr,
  input wire logic          memRdDone,
  input wire logic          memWrDone,
  input wire logic          charWrDone,
  input wire logic [XW-1:0] winRight,
  input wire logic          textMode,
  input wire logic          spriteShow,
  input wire logic [XW-1:0] spriteX,
  input wire logic [XW-1:0] readX,
  input wire logic [YW-1:0] readY,
  input wire logic [XW-1:0] writeX,
  input wire logic [YW-1:0] writeY,
  input wire logic          writeCursorShow,
  input wire logic          textCursorShow
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  logic [7:0] ctlMain_q;
  logic [1:0] rdDir_q;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      ctlMain_q <= 8'h00;
      rdDir_q   <= 2'h0;
    end else if (regWr) begin
      if (regAddr == OFS_CTL_MAIN) ctlMain_q <= regWrData;
      if (regAddr == OFS_RD_ORDER) rdDir_q <= regWrData[1:0];
    end
  end

  a_mode_select: assert property (
    regWr && regAddr == OFS_CTL_MAIN |=> textMode == $past(regWrData[7]))
    else $error("text mode does not follow main control bit 7");
  a_sprite_enable: assert property (
    regWr && regAddr == OFS_CTL_AUX |=> spriteShow == $past(regWrData[7]))
    else $error("sprite show does not follow aux bit 7");
  a_sprite_place: assert property (
    regWr && regAddr == OFS_SPR_X_LO |=> spriteX[7:0] == $past(regWrData))
    else $error("sprite x low byte not applied");
  a_read_hold: assert property (
    memRdDone && ctlMain_q[0] && !regWr |=> $stable(readX) && $stable(readY))
    else $error("read cursor moved while held");
  a_read_step: assert property (
    memRdDone && !ctlMain_q[0] && !regWr && rdDir_q == 2'h0 && readX < winRight
    |=> readX == $past(readX) + 1'b1 && $stable(readY))
    else $error("read cursor step wrong for order 00");
  a_read_private: assert property (
    memRdDone && !memWrDone && !charWrDone && !regWr
    |=> $stable(writeX) && $stable(writeY))
    else $error("read advance moved write cursor");
  a_write_hold: assert property (
    memWrDone && ctlMain_q[1] && !regWr |=> $stable(writeX) && $stable(writeY))
    else $error("write cursor moved while held");
  a_write_graphic: assert property (
    memWrDone && ctlMain_q[7] && !regWr |=> $stable(writeX) && $stable(writeY))
    else $error("write cursor moved in text mode");
  a_show_write: assert property (
    writeCursorShow |-> ctlMain_q[6] && !ctlMain_q[7])
    else $error("write cursor shown while disabled");
  a_show_text: assert property (
    textCursorShow |-> ctlMain_q[6] && ctlMain_q[7])
    else $error("text cursor shown outside text mode");
  a_steady_show: assert property (
    ctlMain_q[6] && !ctlMain_q[5] && !ctlMain_q[7] |-> writeCursorShow)
    else $error("steady write cursor hidden");

  c_read_step: cover property (memRdDone && !ctlMain_q[0]);
  c_blink_off: cover property (writeCursorShow ##1 !writeCursorShow);
  c_text_char: cover property (charWrDone && ctlMain_q[7]);
endmodule : dcc_cursor_properties

bind dcc_cursor_ctrl dcc_cursor_properties #(.XW(XW), .YW(YW)) props (
  .core_clk, .sys_rst, .regAddr, .regWrData, .regWr, .memRdDone, .memWrDone,
  .charWrDone, .winRight, .textMode, .spriteShow, .spriteX, .readX, .readY,
  .writeX, .writeY, .writeCursorShow, .textCursorShow);

// ### verif/tb_display_cursor_control.sv
// Purpose: Self-checking bench of the cursor control block
// Assumes: Host model drives the register port
// Notes:   Window 0..15 by 0..30, font 4 by 6
`timescale 1ns/100ps
module tb_display_cursor_control;
  import dcc_pkg::*;
  logic       core_clk = 1'b0;
  logic       sys_rst  = 1'b1;
  logic [7:0] regAddr, regWrData, regRdData, rdVal;
  logic       regWr, regRd, textMode, spriteShow, wrShow, txtShow;
  logic [3:0] ev = 4'h0; // Read, write, char, frame events
  logic [9:0] spriteX, readX, writeX, textX;
  logic [8:0] spriteY, readY, writeY, textY;
  logic [7:0] colA, colB;
  logic [9:0] winR = 10'h00F;
  logic [8:0] winB = 9'h01E;
  logic       fontRot = 1'b0;
  int         mismatches = 0;
  int         cmpCount = 0;
  logic [9:0] stepX[4] = '{10'h00F, 10'h00D, 10'h00E, 10'h00E};
  logic [8:0] stepY[4] = '{9'h003, 9'h003, 9'h004, 9'h002};
  logic [7:0] zeroList[4] = '{OFS_CTL_MAIN, OFS_CTL_AUX, OFS_BLINK, 8'h50};

  always #4 core_clk = ~core_clk;

  dcc_host_model host (.core_clk, .regRdData, .regAddr, .regWrData, .regWr, .regRd);

  dcc_cursor_ctrl uut (
    .core_clk, .sys_rst, .regAddr, .regWrData, .regWr, .regRd, .regRdData,
    .memRdDone(ev[0]), .memWrDone(ev[1]), .charWrDone(ev[2]), .framePulse(ev[3]),
    .fontWidth(6'h04), .fontHeight(6'h06), .fontRotated(fontRot),
    .winLeft(10'h000), .winRight(winR), .winTop(9'h000), .winBottom(winB),
    .textMode, .spriteShow, .spriteX, .spriteY, .spriteColourA(colA),
    .spriteColourB(colB), .readX, .readY, .writeX, .writeY, .textX, .textY,
    .writeCursorShow(wrShow), .textCursorShow(txtShow));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmpCount++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic pulse(input int k);
    @(posedge core_clk);
    ev[k] <= 1'b1;
    @(posedge core_clk);
    ev[k] <= 1'b0;
    #1;
  endtask : pulse

  task automatic setPos(input logic [7:0] b, input logic [9:0] x, input logic [8:0] y);
    host.wr(b, x[7:0]);
    host.wr(b + 8'h01, {6'h00, x[9:8]});
    host.wr(b + 8'h02, y[7:0]);
    host.wr(b + 8'h03, {7'h00, y[8]});
  endtask : setPos

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", cmpCount, mismatches);
    if (mismatches == 0 && cmpCount > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : test_done

  // Cuts a hang well past the few hundred cycles the tests need
  initial begin
    repeat (5000) @(posedge core_clk);
    mismatches++;
    test_done();
  end

  initial begin
    repeat (2) @(posedge core_clk);
    sys_rst <= 1'b0;
    foreach (zeroList[i]) begin
      host.rd(zeroList[i], rdVal);
      chk(rdVal, 32'h0);
    end
    $display("test reset values done");
    host.show_sprite(8'h5A, 8'hC3, 10'h2F5, 9'h1A7);
    chk({colA, colB}, 32'h5AC3);
    chk(spriteShow, 32'h1);
    chk({spriteX, spriteY}, {10'h2F5, 9'h1A7});
    host.wr(OFS_SPR_X_HI, 8'hFD);
    host.rd(OFS_SPR_X_HI, rdVal);
    chk({rdVal, spriteX}, {8'h01, 10'h1F5});
    host.wr(OFS_CTL_AUX, 8'h00);
    chk(spriteShow, 32'h0);
    $display("test sprite done");
    for (int k = 0; k < 2; k++) begin
      for (int d = 0; d < 4; d++) begin
        if (k == 0) host.wr(OFS_RD_ORDER, 8'(d));
        else host.wr(OFS_CTL_MAIN, 8'(d << 2));
        setPos(k ? OFS_WR_X_LO : OFS_RD_X_LO, 10'h00E, 9'h003);
        pulse(k);
        chk(k ? {writeX, writeY} : {readX, readY}, {stepX[d], stepY[d]});
      end
    end
    $display("test scan orders done");
    host.wr(OFS_CTL_MAIN, 8'h03);
    pulse(0);
    pulse(1);
    chk({readX, readY, writeX, writeY}, {10'h00E, 9'h002, 10'h00E, 9'h002});
    host.wr(OFS_CTL_MAIN, 8'h00);
    host.wr(OFS_RD_ORDER, 8'h00);
    pulse(0);
    chk({readX, readY, writeX, writeY}, {10'h00F, 9'h002, 10'h00E, 9'h002});
    host.wr(OFS_CTL_MAIN, 8'h80);
    pulse(0);
    pulse(1);
    chk({readX, readY, writeX, writeY}, {10'h000, 9'h003, 10'h00E, 9'h002});
    $display("test hold and mode done");
    host.wr(OFS_LINE_GAP, 8'hE3);
    host.rd(OFS_LINE_GAP, rdVal);
    chk(rdVal, 32'h03);
    setPos(OFS_TXT_X_LO, 10'h008, 9'h000);
    pulse(2);
    chk({textX, textY}, {10'h00C, 9'h000});
    pulse(2);
    chk({textX, textY}, {10'h000, 9'h009});
    host.wr(OFS_CTL_MAIN, 8'h82);
    pulse(2);
    host.wr(OFS_CTL_MAIN, 8'h00);
    pulse(2);
    chk({textX, textY, textMode}, {10'h000, 9'h009, 1'b0});
    host.wr(OFS_CTL_MAIN, 8'h80);
    @(posedge core_clk) fontRot <= 1'b1;
    setPos(OFS_TXT_X_LO, 10'h000, 9'h014);
    pulse(2);
    pulse(2);
    chk({textX, textY, textMode}, {10'h009, 9'h000, 1'b1});
    $display("test text cursor done");
    host.wr(OFS_BLINK, 8'h02);
    host.wr(OFS_CTL_MAIN, 8'h40);
    chk({wrShow, txtShow}, 32'h2);
    host.wr(OFS_CTL_MAIN, 8'hC0);
    chk({wrShow, txtShow}, 32'h1);
    host.wr(OFS_CTL_MAIN, 8'h60);
    chk({wrShow, txtShow}, 32'h2);
    pulse(3);
    chk({wrShow, txtShow}, 32'h2);
    pulse(3);
    chk({wrShow, txtShow}, 32'h0);
    pulse(3);
    pulse(3);
    chk({wrShow, txtShow}, 32'h2);
    $display("test show and blink done");
    test_done();
  end
endmodule : tb_display_cursor_control
